//--- logic/csfs_cfg.svh
// constants for the store / flag-set / stop execution block
`ifndef CSFS_CFG_SVH
`define CSFS_CFG_SVH

// register byte offsets on the wishbone slave
`define CSFS_OFF_CTRL  8'h00
`define CSFS_OFF_ACC   8'h04
`define CSFS_OFF_SP    8'h08
`define CSFS_OFF_IX    8'h0c
`define CSFS_OFF_IY    8'h10
`define CSFS_OFF_PC    8'h14
`define CSFS_OFF_FLAGS 8'h18
`define CSFS_OFF_STAT  8'h1c

// condition flag bit positions
`define CSFS_CC_S      7
`define CSFS_CC_X      6
`define CSFS_CC_I      4
`define CSFS_CC_N      3
`define CSFS_CC_Z      2
`define CSFS_CC_V      1

// status register fields
`define CSFS_ST_ILL    4
`define CSFS_ST_SVC    5
`define CSFS_ST_STOP   6

// reset values
`define CSFS_FLAGS_RST 8'hd0
`define CSFS_PC_RST    16'h0000

// opcodes handled here
`define CSFS_OP_NOP    8'h01
`define CSFS_OP_SETOVF 8'h0b
`define CSFS_OP_SETMSK 8'h0f
`define CSFS_OP_PFXY   8'h18
`define CSFS_OP_SWTRAP 8'h3f
`define CSFS_OP_STOP   8'hcf
`define CSFS_OP_STA_D  8'h97
`define CSFS_OP_STA_E  8'hb7
`define CSFS_OP_STA_X  8'ha7
`define CSFS_OP_STB_D  8'hd7
`define CSFS_OP_STB_E  8'hf7
`define CSFS_OP_STB_X  8'he7
`define CSFS_OP_DBL_D  8'hdd
`define CSFS_OP_DBL_E  8'hfd
`define CSFS_OP_DBL_X  8'hed
`define CSFS_OP_SPS_D  8'h9f
`define CSFS_OP_SPS_E  8'hbf
`define CSFS_OP_SPS_X  8'haf

// address driven on the indexed dummy cycle
`define CSFS_DUMMY_ADDR 16'hffff

`endif

//--- logic/csfs_pkg.sv
// types shared by the execution block
package csfs_pkg;

  // execution sequencer states
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_FETCH = 4'h1,
    S_OPND  = 4'h2,
    S_OPND2 = 4'h3,
    S_DUMMY = 4'h4,
    S_WHI   = 4'h5,
    S_WLO   = 4'h6,
    S_STOP  = 4'h7,
    S_SVC   = 4'h8
  } csfs_state_t;

  // source of a service request handed to the stacking sequencer
  typedef enum logic [1:0] {
    SRC_HPEXT    = 2'h0,
    SRC_MASKABLE = 2'h1,
    SRC_SWINSTR  = 2'h2
  } csfs_svc_src_t;

  // one processor bus cycle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        read;
  } csfs_bus_t;

  // service request to the rest of the core
  typedef struct packed {
    logic          valid;
    csfs_svc_src_t src;
  } csfs_svc_t;

endpackage : csfs_pkg

//--- logic/csfs_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module csfs_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin and clean level
  input  wire logic pin_i,
  output logic      lvl_o
);

  logic q1_r;
  logic q2_r;
  logic q3_r;

  // q1 only feeds q2; the level moves once q2 and q3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q1_r  <= RST_VAL;
      q2_r  <= RST_VAL;
      q3_r  <= RST_VAL;
      lvl_o <= RST_VAL;
    end else begin
      q1_r <= pin_i;
      q2_r <= q1_r;
      q3_r <= q2_r;
      if (q2_r == q3_r) begin
        lvl_o <= q3_r;
      end
    end
  end

endmodule : csfs_pin_sync

//--- logic/csfs_core.sv
// store, flag-set and stop instruction execution with wishbone register port
`timescale 1ns/1ns
`include "csfs_cfg.svh"

module csfs_core
  import csfs_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone register slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // processor memory bus
  output csfs_pkg::csfs_bus_t   mem_bus_o,
  input  wire logic [7:0]       mem_rdata_i,
  // interrupt pins, active low
  input  wire logic             irq_n_i,
  input  wire logic             hp_ext_irq_n_i,
  // stacking sequencer hand-off and clock control
  output csfs_pkg::csfs_svc_t   svc_o,
  input  wire logic             svc_ack_i,
  output logic                  clk_stop_o
);
  import csfs_pkg::*;

  csfs_state_t st_r;
  logic [15:0] pc_r;
  logic [15:0] acc_r;      // first accumulator high, second low
  logic [15:0] sp_r;
  logic [15:0] ix_r;
  logic [15:0] iy_r;
  logic [15:0] ea_r;
  logic [7:0]  flags_r;
  logic [7:0]  op_r;
  logic        pfx_r;
  logic        ill_r;
  logic        run_r;
  logic        irq_n_s;
  logic        hpx_n_s;
  logic        wb_req;
  logic        wb_wr;
  logic        cfg_wr;
  logic [15:0] src16;
  logic [7:0]  src8;
  logic        is_byte;

  // pins arrive asynchronously
  csfs_pin_sync #(.RST_VAL(1'b1)) u_sync_irq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (irq_n_i),
    .lvl_o (irq_n_s)
  );
  csfs_pin_sync #(.RST_VAL(1'b1)) u_sync_hpx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (hp_ext_irq_n_i),
    .lvl_o (hpx_n_s)
  );

  // request decode; a request is taken once, in the cycle before ack
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;
  // registers other than control and status only take writes while the sequencer is parked
  assign cfg_wr = wb_wr & (st_r == S_IDLE);

  // store operand selection from the opcode's low nibble and bit 6
  assign is_byte = (op_r[3:0] == 4'h7);
  assign src8    = op_r[6] ? acc_r[7:0] : acc_r[15:8];
  assign src16   = (op_r[3:0] == 4'hd) ? acc_r : sp_r;

  function automatic logic [15:0] lanes16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    lanes16 = {sel[1] ? dat[15:8] : old[15:8],
               sel[0] ? dat[7:0]  : old[7:0]};
  endfunction : lanes16

  function automatic logic is_store(input logic [7:0] op);
    case (op)
      `CSFS_OP_STA_D, `CSFS_OP_STA_E, `CSFS_OP_STA_X,
      `CSFS_OP_STB_D, `CSFS_OP_STB_E, `CSFS_OP_STB_X,
      `CSFS_OP_DBL_D, `CSFS_OP_DBL_E, `CSFS_OP_DBL_X,
      `CSFS_OP_SPS_D, `CSFS_OP_SPS_E, `CSFS_OP_SPS_X: is_store = 1'b1;
      default: is_store = 1'b0;
    endcase
  endfunction : is_store

  // run control may be written at any time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
    end else if (wb_wr && wb_adr_i == `CSFS_OFF_CTRL && wb_sel_i[0]) begin
      run_r <= wb_dat_i[0];
    end
  end

  // wishbone answer: one wait state, ack dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `CSFS_OFF_CTRL: wb_dat_o <= {31'h0000_0000, run_r};
          `CSFS_OFF_ACC:  wb_dat_o <= {16'h0000, acc_r};
          `CSFS_OFF_SP:   wb_dat_o <= {16'h0000, sp_r};
          `CSFS_OFF_IX:   wb_dat_o <= {16'h0000, ix_r};
          `CSFS_OFF_IY:   wb_dat_o <= {16'h0000, iy_r};
          `CSFS_OFF_PC:   wb_dat_o <= {16'h0000, pc_r};
          `CSFS_OFF_FLAGS: wb_dat_o <= {24'h00_0000, flags_r};
          `CSFS_OFF_STAT: wb_dat_o <= {25'h000_0000, clk_stop_o,
                                       svc_o.valid, ill_r, st_r};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // instruction sequencer, programmer registers and bus cycles
  always_ff @(posedge clk_i) begin
    logic       fin;
    logic [7:0] cc;
    logic       hpx;
    logic       irq;
    fin = 1'b0;
    cc  = flags_r;
    hpx = ~hpx_n_s;
    irq = ~irq_n_s;
    if (rst_i) begin
      st_r       <= S_IDLE;
      pc_r       <= `CSFS_PC_RST;
      flags_r    <= `CSFS_FLAGS_RST;
      acc_r      <= 16'h0000;
      sp_r       <= 16'h0000;
      ix_r       <= 16'h0000;
      iy_r       <= 16'h0000;
      ea_r       <= 16'h0000;
      op_r       <= 8'h00;
      pfx_r      <= 1'b0;
      ill_r      <= 1'b0;
      mem_bus_o  <= '{addr: `CSFS_DUMMY_ADDR, wdata: 8'h00, read: 1'b1};
      svc_o      <= '{valid: 1'b0, src: SRC_HPEXT};
      clk_stop_o <= 1'b0;
    end else begin
      clk_stop_o <= 1'b0;
      // clearing the sticky illegal flag loses to a new one
      if (wb_wr && wb_adr_i == `CSFS_OFF_STAT && wb_sel_i[0] &&
          wb_dat_i[`CSFS_ST_ILL]) begin
        ill_r <= 1'b0;
      end
      unique case (st_r)
        S_IDLE: begin
          if (cfg_wr) begin
            unique case (wb_adr_i)
              `CSFS_OFF_ACC: acc_r <= lanes16(acc_r, wb_dat_i, wb_sel_i);
              `CSFS_OFF_SP:  sp_r  <= lanes16(sp_r, wb_dat_i, wb_sel_i);
              `CSFS_OFF_IX:  ix_r  <= lanes16(ix_r, wb_dat_i, wb_sel_i);
              `CSFS_OFF_IY:  iy_r  <= lanes16(iy_r, wb_dat_i, wb_sel_i);
              `CSFS_OFF_PC:  pc_r  <= lanes16(pc_r, wb_dat_i, wb_sel_i);
              `CSFS_OFF_FLAGS: if (wb_sel_i[0]) begin
                // the high-priority mask may only be kept or cleared
                cc = wb_dat_i[7:0];
                cc[`CSFS_CC_X] = wb_dat_i[`CSFS_CC_X] &
                                 flags_r[`CSFS_CC_X];
              end
              default: ;
            endcase
          end
          if (run_r) begin
            st_r      <= S_FETCH;
            mem_bus_o <= '{addr: pc_r, wdata: 8'h00, read: 1'b1};
          end
        end
        S_FETCH: begin
          op_r      <= mem_rdata_i;
          pfx_r     <= (mem_rdata_i == `CSFS_OP_PFXY);
          pc_r      <= pc_r + 16'h0001;
          mem_bus_o <= '{addr: pc_r + 16'h0001, wdata: 8'h00, read: 1'b1};
          st_r      <= S_OPND;
        end
        S_OPND: begin
          if (pfx_r) begin
            // second opcode byte after the y prefix
            op_r <= mem_rdata_i;
            if (mem_rdata_i == `CSFS_OP_STA_X ||
                mem_rdata_i == `CSFS_OP_STB_X ||
                mem_rdata_i == `CSFS_OP_DBL_X ||
                mem_rdata_i == `CSFS_OP_SPS_X) begin
              pc_r      <= pc_r + 16'h0001;
              mem_bus_o <= '{addr: pc_r + 16'h0001, wdata: 8'h00, read: 1'b1};
              st_r      <= S_OPND2;
            end else begin
              ill_r <= 1'b1;
              fin   = 1'b1;
            end
          end else if (op_r == `CSFS_OP_SETMSK) begin
            cc[`CSFS_CC_I] = 1'b1;
            fin = 1'b1;
          end else if (op_r == `CSFS_OP_SETOVF) begin
            cc[`CSFS_CC_V] = 1'b1;
            fin = 1'b1;
          end else if (op_r == `CSFS_OP_NOP) begin
            fin = 1'b1;
          end else if (op_r == `CSFS_OP_STOP) begin
            // one byte long: pc already points past it
            if (flags_r[`CSFS_CC_S]) begin
              fin = 1'b1;
            end else begin
              st_r       <= S_STOP;
              clk_stop_o <= 1'b1;
            end
          end else if (op_r == `CSFS_OP_SWTRAP) begin
            // software interrupt ignores the mask
            svc_o <= '{valid: 1'b1, src: SRC_SWINSTR};
            st_r  <= S_SVC;
          end else if (is_store(op_r)) begin
            pc_r <= pc_r + 16'h0001;
            unique case (op_r[5:4])
              2'b01: begin
                // direct: page zero address, straight to data
                ea_r      <= {8'h00, mem_rdata_i};
                mem_bus_o <= '{addr: {8'h00, mem_rdata_i},
                               wdata: is_byte ? src8 : src16[15:8],
                               read: 1'b0};
                st_r      <= S_WHI;
              end
              2'b11: begin
                ea_r[15:8] <= mem_rdata_i;
                mem_bus_o  <= '{addr: pc_r + 16'h0001, wdata: 8'h00,
                                read: 1'b1};
                st_r       <= S_OPND2;
              end
              default: begin
                ea_r      <= ix_r + {8'h00, mem_rdata_i};
                mem_bus_o <= '{addr: `CSFS_DUMMY_ADDR, wdata: 8'h00,
                               read: 1'b1};
                st_r      <= S_DUMMY;
              end
            endcase
          end else begin
            ill_r <= 1'b1;
            fin   = 1'b1;
          end
        end
        S_OPND2: begin
          pc_r <= pc_r + 16'h0001;
          if (pfx_r) begin
            ea_r      <= iy_r + {8'h00, mem_rdata_i};
            mem_bus_o <= '{addr: `CSFS_DUMMY_ADDR, wdata: 8'h00,
                           read: 1'b1};
            st_r      <= S_DUMMY;
          end else begin
            ea_r[7:0] <= mem_rdata_i;
            mem_bus_o <= '{addr: {ea_r[15:8], mem_rdata_i},
                           wdata: is_byte ? src8 : src16[15:8],
                           read: 1'b0};
            st_r      <= S_WHI;
          end
        end
        S_DUMMY: begin
          mem_bus_o <= '{addr: ea_r, wdata: is_byte ? src8 : src16[15:8],
                         read: 1'b0};
          st_r      <= S_WHI;
        end
        S_WHI: begin
          // flags follow the stored value; overflow always clears
          cc[`CSFS_CC_V] = 1'b0;
          if (is_byte) begin
            cc[`CSFS_CC_N] = src8[7];
            cc[`CSFS_CC_Z] = (src8 == 8'h00);
            fin = 1'b1;
          end else begin
            cc[`CSFS_CC_N] = src16[15];
            cc[`CSFS_CC_Z] = (src16 == 16'h0000);
            mem_bus_o <= '{addr: ea_r + 16'h0001, wdata: src16[7:0],
                           read: 1'b0};
            st_r      <= S_WLO;
          end
        end
        S_WLO: begin
          fin = 1'b1;
        end
        S_STOP: begin
          // core state is frozen; only wake sources are watched
          if (hpx && !flags_r[`CSFS_CC_X]) begin
            cc[`CSFS_CC_X] = 1'b1;
            cc[`CSFS_CC_I] = 1'b1;
            svc_o <= '{valid: 1'b1, src: SRC_HPEXT};
            st_r  <= S_SVC;
          end else if (hpx) begin
            st_r      <= S_FETCH;
            mem_bus_o <= '{addr: pc_r, wdata: 8'h00, read: 1'b1};
          end else if (irq && !flags_r[`CSFS_CC_I]) begin
            cc[`CSFS_CC_I] = 1'b1;
            svc_o <= '{valid: 1'b1, src: SRC_MASKABLE};
            st_r  <= S_SVC;
          end else begin
            clk_stop_o <= 1'b1;
          end
        end
        S_SVC: begin
          if (svc_ack_i) begin
            svc_o.valid <= 1'b0;
            fin = 1'b1;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
      // instruction boundary: high-priority line first, then maskable
      if (fin) begin
        mem_bus_o <= '{addr: pc_r, wdata: 8'h00, read: 1'b1};
        if (hpx && !cc[`CSFS_CC_X]) begin
          cc[`CSFS_CC_X] = 1'b1;
          cc[`CSFS_CC_I] = 1'b1;
          svc_o <= '{valid: 1'b1, src: SRC_HPEXT};
          st_r  <= S_SVC;
        end else if (irq && !cc[`CSFS_CC_I]) begin
          cc[`CSFS_CC_I] = 1'b1;
          svc_o <= '{valid: 1'b1, src: SRC_MASKABLE};
          st_r  <= S_SVC;
        end else if (run_r) begin
          st_r <= S_FETCH;
        end else begin
          st_r <= S_IDLE;
        end
      end
      flags_r <= cc;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sei_sets_mask: assert property (
    st_r == S_OPND && !pfx_r && op_r == `CSFS_OP_SETMSK
    |=> flags_r[`CSFS_CC_I] && flags_r[7:5] == $past(flags_r[7:5]) &&
        flags_r[3:0] == $past(flags_r[3:0]))
    else $error("mask set instruction disturbed flags");
  a_mask_blocks_irq: assert property (
    svc_o.valid && !$past(svc_o.valid) && svc_o.src == SRC_MASKABLE
    |-> !$past(flags_r[`CSFS_CC_I]))
    else $error("maskable request taken while masked");
  a_sev_sets_ovf: assert property (
    st_r == S_OPND && !pfx_r && op_r == `CSFS_OP_SETOVF
    |=> flags_r[`CSFS_CC_V] && flags_r[7:2] == $past(flags_r[7:2]))
    else $error("overflow set instruction disturbed flags");
  a_byte_store_flags: assert property (
    st_r == S_WHI && is_byte
    |-> !mem_bus_o.read && mem_bus_o.wdata == src8
    ##1 flags_r[`CSFS_CC_N] == $past(src8[7]) && !flags_r[`CSFS_CC_V])
    else $error("byte store data or flags wrong");
  a_dbl_low_byte: assert property (
    st_r == S_WLO |-> mem_bus_o.addr == $past(mem_bus_o.addr) + 16'h0001
    && mem_bus_o.wdata == src16[7:0] && !mem_bus_o.read)
    else $error("low byte not written one above");
  a_idx_dummy: assert property (
    st_r == S_DUMMY |-> mem_bus_o.addr == `CSFS_DUMMY_ADDR &&
    mem_bus_o.read ##1 st_r == S_WHI)
    else $error("indexed dummy cycle wrong");
  a_stop_as_nop: assert property (
    st_r == S_OPND && !pfx_r && op_r == `CSFS_OP_STOP &&
    flags_r[`CSFS_CC_S] |=> st_r != S_STOP && flags_r == $past(flags_r))
    else $error("disabled stop did not act as no-op");
  a_stop_frozen: assert property (
    st_r == S_STOP |=> $stable(acc_r) && $stable(sp_r) &&
    $stable(pc_r) && $stable(mem_bus_o))
    else $error("state moved during stop");
  a_stop_wake: assert property (
    st_r == S_STOP && hpx_n_s && (irq_n_s || flags_r[`CSFS_CC_I])
    |=> st_r == S_STOP && clk_stop_o)
    else $error("stop left without a wake source");
  a_wake_continue: assert property (
    st_r == S_STOP && !hpx_n_s && flags_r[`CSFS_CC_X]
    |=> st_r == S_FETCH && mem_bus_o.addr == $past(pc_r) && !svc_o.valid)
    else $error("masked wake did not resume fetch");
  a_mask_no_set: assert property (
    $rose(flags_r[`CSFS_CC_X]) |-> svc_o.valid && svc_o.src == SRC_HPEXT)
    else $error("high-priority mask set without recognition");

endmodule : csfs_core

//--- verif/csfs_mem_model.sv
// memory model standing on the processor bus of the execution block
`timescale 1ns/1ns
module csfs_mem_model
  import csfs_pkg::*;
(
  // clock
  input  wire logic           clk_i,
  // processor bus from the core
  input  csfs_pkg::csfs_bus_t bus_i,
  output logic [7:0]          rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  // fill with a marker so that a store of zero is visible
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h5a;
    last_r = 8'h00;
  end

  // a write lands at the edge that ends a write cycle
  always @(posedge clk_i) begin
    if (bus_i.read === 1'b0) mem[bus_i.addr] <= bus_i.wdata;
    last_r <= rdata_o;
  end

  // no wait states; outside read cycles the lines show the inverse of the previous cycle's byte
  assign rdata_o = bus_i.read ? mem[bus_i.addr] : ~last_r;
endmodule : csfs_mem_model

//--- verif/cpu_store_flagset_stop_exec_bench.sv
// self-checking bench for the store, flag-set and stop execution block
`timescale 1ns/1ns
`include "csfs_cfg.svh"
module cpu_store_flagset_stop_exec_bench;
  import csfs_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, mem_rdata_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        irq_n_i, hp_ext_irq_n_i, svc_ack_i, clk_stop_o, mon_run;
  csfs_bus_t   mem_bus_o, save;
  csfs_svc_t   svc_o;
  logic [15:0] mon_pc;
  int          fails, compares, n_cyc, n_ffff, n_wr;
  logic [15:0] ea [24] = '{16'h0040, 16'h0041, 16'h0301, 16'h0401,
    16'h0042, 16'h0043, 16'h0302, 16'h0402, 16'h0044, 16'h0045, 16'h0046,
    16'h0047, 16'h0304, 16'h0305, 16'h0404, 16'h0405, 16'h0048, 16'h0049,
    16'h004a, 16'h004b, 16'h0306, 16'h0307, 16'h0406, 16'h0407};

  csfs_core u_csfs_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_bus_o(mem_bus_o), .mem_rdata_i(mem_rdata_i),
    .irq_n_i(irq_n_i), .hp_ext_irq_n_i(hp_ext_irq_n_i), .svc_o(svc_o),
    .svc_ack_i(svc_ack_i), .clk_stop_o(clk_stop_o));
  csfs_mem_model u_csfs_mem_model (.clk_i(clk_i), .bus_i(mem_bus_o),
    .rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // bus cycle counter from the first fetch until the core halts or hands off
  always @(posedge clk_i) begin
    if (mem_bus_o.addr === mon_pc && mem_bus_o.read === 1'b1) mon_run = 1'b1;
    if (mon_run && clk_stop_o === 1'b0 && svc_o.valid === 1'b0) begin
      n_cyc++;
      if (mem_bus_o.addr === 16'hffff && mem_bus_o.read === 1'b1) n_ffff++;
      if (mem_bus_o.read === 1'b0) n_wr++;
    end
  end

  task automatic tally_and_finish;
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin @(posedge clk_i); k++; end
    while (wb_ack_o !== 1'b1 && k < 50);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (k >= 50) begin chk("wb_ack", 1, 0); tally_and_finish; end
  endtask : wb

  // bounded wait for the halt request or a service request
  task automatic wait_for(input bit svc);
    int k;
    k = 0;
    do begin @(posedge clk_i); k++; end
    while ((svc ? svc_o.valid : clk_stop_o) !== 1'b1 && k < 300);
    if (k >= 300) begin chk("wait", 1, 0); tally_and_finish; end
  endtask : wait_for

  // reset, load a program and the registers; the core is left idle
  task automatic setup(input logic [15:0] pc, input logic [7:0] flg,
                       input logic [15:0] acc, input int n,
                       input logic [343:0] code);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < n; i++)
      u_csfs_mem_model.mem[pc + i] = code[8*(n-1-i) +: 8];
    wb(1'b1, `CSFS_OFF_ACC, {16'h0000, acc}, q);
    wb(1'b1, `CSFS_OFF_SP, 32'h0000_0000, q);
    wb(1'b1, `CSFS_OFF_IX, 32'h0000_0300, q);
    wb(1'b1, `CSFS_OFF_IY, 32'h0000_0400, q);
    wb(1'b1, `CSFS_OFF_PC, {16'h0000, pc}, q);
    wb(1'b1, `CSFS_OFF_FLAGS, {24'h000000, flg}, q);
    mon_pc = pc;
  endtask : setup

  task automatic go;
    mon_run = 1'b0;
    n_cyc = 0;
    n_ffff = 0;
    n_wr = 0;
    wb(1'b1, `CSFS_OFF_CTRL, 32'h0000_0001, q);
  endtask : go

  task automatic svc_done;
    svc_ack_i <= 1'b1;
    @(posedge clk_i);
    svc_ack_i <= 1'b0;
    irq_n_i <= 1'b1;
    hp_ext_irq_n_i <= 1'b1;
  endtask : svc_done

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, svc_ack_i, mon_run} = 5'h00;
    {wb_adr_i, wb_dat_i, mon_pc} = '0;
    wb_sel_i = 4'h3;
    {irq_n_i, hp_ext_irq_n_i, rst_i} = 3'h7;
    {fails, compares} = 0;
    // mask and overflow set, every store opcode and mode, then stop with only the high-priority mask clear
    setup(16'h0100, 8'h00, 16'h1234, 43,
      {176'h0f0b9740b70041a70118a701d742f70043e70218e702,
       168'hdd44fd0046ed0418ed049f48bf004aaf0618af06cf});
    wb(1'b1, `CSFS_OFF_FLAGS, 32'h0000_0040, q);
    wb(1'b0, `CSFS_OFF_FLAGS, 32'h0, q);
    chk("flags_x_set", 32'h00, q & 32'hff);
    go();
    wait_for(1'b0);
    chk("cycles", 78, 32'(n_cyc));
    chk("dummy_reads", 8, 32'(n_ffff));
    chk("writes", 24, 32'(n_wr));
    for (int i = 0; i < 24; i++)
      chk("mem", (i < 4) ? 8'h12 : (i < 8) ? 8'h34 : (i < 16) ?
        ((i % 2) ? 8'h34 : 8'h12) : 8'h00, u_csfs_mem_model.mem[ea[i]]);
    wb(1'b0, `CSFS_OFF_FLAGS, 32'h0, q);
    chk("flags", 32'h14, q & 32'hff);
    wb(1'b0, `CSFS_OFF_ACC, 32'h0, q);
    chk("acc", 32'h1234, q & 32'hffff);
    save = mem_bus_o;
    irq_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("stopped", 1, {31'h0, clk_stop_o});
    chk("bus_held", {7'h0, save}, {7'h0, mem_bus_o});
    irq_n_i <= 1'b1;
    hp_ext_irq_n_i <= 1'b0;
    wait_for(1'b1);
    chk("src", 32'(SRC_HPEXT), {30'h0, svc_o.src});
    svc_done();
    // stop as a no-operation, a negative byte store, then a software trap
    setup(16'h0600, 8'h90, 16'h8000, 5, 344'hcfb700603f);
    go();
    wait_for(1'b1);
    chk("cycles", 8, 32'(n_cyc));
    chk("mem", 32'h80, {24'h0, u_csfs_mem_model.mem[16'h0060]});
    chk("src", 32'(SRC_SWINSTR), {30'h0, svc_o.src});
    wb(1'b0, `CSFS_OFF_FLAGS, 32'h0, q);
    chk("flags", 32'h88, q & 32'hef);
    svc_done();
    // masked high-priority wake resumes at the byte after stop
    setup(16'h0200, 8'h50, 16'h0000, 3, 344'h01cf3f);
    go();
    wait_for(1'b0);
    hp_ext_irq_n_i <= 1'b0;
    wait_for(1'b1);
    chk("src", 32'(SRC_SWINSTR), {30'h0, svc_o.src});
    svc_done();
    // maskable request with its mask clear ends stop
    setup(16'h0700, 8'h40, 16'h0000, 2, 344'hcf3f);
    go();
    wait_for(1'b0);
    irq_n_i <= 1'b0;
    wait_for(1'b1);
    chk("src", 32'(SRC_MASKABLE), {30'h0, svc_o.src});
    svc_done();
    wb(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", 32'h0, q);
    tally_and_finish();
  end
endmodule : cpu_store_flagset_stop_exec_bench
